//--- rtl/pil_ctrl.sv
`include "pil_params.svh"

// Behaviour
// - Level holds two condition bits plus enable
// - Disarmed level ignores incoming signals completely
// - Armed level captures signal, becomes waiting
// - Waiting holds until every grant condition met
// - Disabled level still makes all other transitions
// - Disabled waiting level drops out of priority chain
// - Activation needs processor at interruptible point
// - Counter level triggered by paired count zero
// - Internal inhibit blocks whole input/output group
// - Up to fourteen external groups, sixteen levels
// - Group priority order set by configuration
// - External inhibit blocks all external groups
// - Fixed priority inside group, first highest
// - Each level individually disarmed or disabled
// - Program command triggers any level
// - Active coded 1 0, processor acknowledges
// - Inhibit off, nothing higher active or eligible
// - Override group always ranks above others
module pil_ctrl
    import pil_pkg::*;
#(
    parameter int NUM_EXT = `PIL_EXT_GROUPS,
    parameter int NUM_CNT = `PIL_CNT_LEVELS
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [`PIL_OVR_LEVELS-1:0] ovr_trig_i,
    input wire logic [NUM_CNT-1:0] cnt_zero_i,
    input wire logic [`PIL_IO_LEVELS-1:0] io_trig_i,
    input wire logic [NUM_EXT*16-1:0] ext_trig_i,
    input wire logic cpu_intpt_i,
    input wire logic cpu_ack_i,
    output logic req_o,
    output logic [8:0] req_level_o,
    output logic act_o,
    output logic [8:0] act_level_o,
    output logic cur_valid_o,
    output logic [8:0] cur_level_o,
    output logic irq_o
);

    // ----------------------------------------------------------------
    // Sizes and elaboration check
    // ----------------------------------------------------------------
    // Fixed groups first, external after
    localparam int NG = `PIL_FIXED_GROUPS + NUM_EXT;
    localparam int NL = NG * `PIL_GRP_SLOTS;

    // Counter levels pair with the four count pulse levels of override
    if (NUM_EXT < 1 || NUM_EXT > 14 || NUM_CNT < 1 || NUM_CNT > 4) begin : g_bad_cfg
        $error("pil_ctrl: NUM_EXT must be 1..14 and NUM_CNT 1..4");
    end

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Whether a flat level number names a populated level
    function automatic logic lvl_exists(input pil_lvl_t idx);
        logic [4:0] g;
        logic [3:0] p;
        logic r;
        g = idx[8:4];
        p = idx[3:0];
        // Fixed groups are partly filled
        case (g)
            `PIL_GRP_OVR: r = (p < 4'(`PIL_OVR_LEVELS));
            `PIL_GRP_CNT: r = (p < 4'(NUM_CNT));
            `PIL_GRP_IO: r = (p < 4'(`PIL_IO_LEVELS));
            default: r = (g < 5'(NG));
        endcase
        return r;
    endfunction

    // First set bit wins: fixed order inside a group
    function automatic logic [3:0] first_pos(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        // Scan down: lowest set bit left last
        for (int k = 15; k >= 0; k--) begin
            if (v[k]) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Registers and level state
    // ----------------------------------------------------------------
    // Inhibits and group order
    logic [1:0] ctrl;
    logic [31:0] ord_lo;
    logic [31:0] ord_hi;

    // Level named by the last command
    pil_lvl_t sel_lvl;

    // Sticky events and their mask
    logic [2:0] int_sts;
    logic [2:0] int_msk;

    // Every slot, filled or not
    pil_cond_t cond [NL];
    logic en [NL];

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // One strobe per writable register
    wire wr_ctrl = wr_i && (addr_i == `PIL_OFF_CTRL);
    wire wr_ord_lo = wr_i && (addr_i == `PIL_OFF_ORD_LO);
    wire wr_ord_hi = wr_i && (addr_i == `PIL_OFF_ORD_HI);
    wire wr_lcmd = wr_i && (addr_i == `PIL_OFF_LCMD);
    wire wr_ists = wr_i && (addr_i == `PIL_OFF_ISTS);
    wire wr_imsk = wr_i && (addr_i == `PIL_OFF_IMSK);

    // Command fields
    wire pil_cmd_t cmd_code = wdata_i[`PIL_LCMD_CODE_LSB +: 4];
    wire pil_lvl_t cmd_lvl = wdata_i[`PIL_LVL_MSB:0];
    wire cmd_ok = wr_lcmd && lvl_exists(cmd_lvl);
    wire cmd_bad = wr_lcmd && !lvl_exists(cmd_lvl);

    // Inhibits and order word
    wire int_inh = ctrl[`PIL_CTRL_INT_INH];
    wire ext_inh = ctrl[`PIL_CTRL_EXT_INH];
    wire [63:0] ord_all = {ord_hi, ord_lo};

    // ----------------------------------------------------------------
    // Trigger sources gathered per flat level
    // ----------------------------------------------------------------
    logic [NL-1:0] trig_all;
    always_comb begin
        trig_all = '0;
        trig_all[`PIL_OVR_LEVELS-1:0] = ovr_trig_i;
        // Zero result only counts while its count pulse level is in service
        for (int k = 0; k < NUM_CNT; k++) begin
            trig_all[16 + k] = cnt_zero_i[k]
                && (cond[`PIL_CNT_PULSE_BASE + k] == `PIL_COND_ACT);
        end
        // Other groups map straight through
        trig_all[32 +: `PIL_IO_LEVELS] = io_trig_i;
        trig_all[48 +: NUM_EXT*16] = ext_trig_i;
    end

    // ----------------------------------------------------------------
    // Eligibility and activity per level
    // ----------------------------------------------------------------
    logic [NL-1:0] elig;
    logic [NL-1:0] isact;
    for (genvar i = 0; i < NL; i++) begin : g_flags
        localparam int GI = i / 16;
        // Group inhibits: internal for I/O group, external for external groups; override and counter groups never inhibited
        wire inh = (GI == 2 && int_inh)
            || (GI >= 3 && ext_inh);
        // Disabled or inhibited waiting levels leave the chain
        assign elig[i] = (cond[i] == `PIL_COND_WAIT) && en[i] && !inh;
        // Actives block whatever their inhibit
        assign isact[i] = (cond[i] == `PIL_COND_ACT);
    end

    // ----------------------------------------------------------------
    // Per-group winners and keys
    // ----------------------------------------------------------------
    logic [NG-1:0] gv_e;
    logic [NG-1:0] gv_a;
    pil_key_t gk_e [NG];
    pil_key_t gk_a [NG];
    for (genvar g = 0; g < NG; g++) begin : g_grp
        wire [15:0] ve = elig[g*16 +: 16];
        wire [15:0] va = isact[g*16 +: 16];
        // Override has rank zero; others one plus their configured order
        wire [4:0] rank = (g == 0) ? 5'h00
            : 5'({1'b0, ord_all[((g == 0) ? 0 : g - 1)*4 +: 4]} + 5'h01);
        // Presence and best member key
        assign gv_e[g] = |ve;
        assign gv_a[g] = |va;
        assign gk_e[g] = {rank, 5'(g), first_pos(ve)};
        assign gk_a[g] = {rank, 5'(g), first_pos(va)};
    end

    // ----------------------------------------------------------------
    // Global winner among groups, lowest key first
    // ----------------------------------------------------------------
    pil_key_t best_e;
    pil_key_t best_a;
    logic best_e_v;
    logic best_a_v;

    // Few groups, so a plain scan
    always_comb begin
        best_e = '1;
        best_a = '1;
        best_e_v = 1'b0;
        best_a_v = 1'b0;
        for (int g = 0; g < NG; g++) begin
            if (gv_e[g] && (!best_e_v || gk_e[g] < best_e)) begin
                best_e = gk_e[g];
                best_e_v = 1'b1;
            end
            if (gv_a[g] && (!best_a_v || gk_a[g] < best_a)) begin
                best_a = gk_a[g];
                best_a_v = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Grant decision
    // ----------------------------------------------------------------
    // Level numbers are the key low bits
    wire pil_lvl_t cand_lvl = best_e[8:0];
    wire pil_lvl_t cur_lvl = best_a[8:0];
    // An active level, even in an inhibited group, still blocks lower ones
    wire cand_beats = best_e_v && (!best_a_v || best_e < best_a);
    // A bus command to the same level this cycle takes precedence
    wire grant = cand_beats && cpu_intpt_i && cpu_ack_i
        && !(cmd_ok && cmd_lvl == cand_lvl);

    // ----------------------------------------------------------------
    // Level state machines
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NL; i++) begin : g_lvl
        // Command aimed at this level
        wire hit = cmd_ok && (cmd_lvl == 9'(i));
        wire sw_trig = hit && (cmd_code == `PIL_CMD_TRIGGER);
        // Next condition and enable
        pil_cond_t next_cond;
        logic next_en;

        // Command first, then trigger on the result, then activation
        always_comb begin
            next_cond = cond[i];
            next_en = en[i];
            if (hit) begin
                case (cmd_code)
                    `PIL_CMD_ARM: next_cond = `PIL_COND_ARM;
                    `PIL_CMD_DISARM: next_cond = `PIL_COND_DIS;
                    `PIL_CMD_ENABLE: next_en = 1'b1;
                    `PIL_CMD_DISABLE: next_en = 1'b0;
                    `PIL_CMD_RELEASE: begin
                        if (cond[i] == `PIL_COND_ACT) begin
                            next_cond = `PIL_COND_ARM;
                        end
                    end
                    `PIL_CMD_ARM_EN: begin
                        next_cond = `PIL_COND_ARM;
                        next_en = 1'b1;
                    end
                    default: next_cond = cond[i];
                endcase
            end
            // Only an armed level remembers a signal; disarmed drops it
            if (next_cond == `PIL_COND_ARM && (trig_all[i] || sw_trig)) begin
                next_cond = `PIL_COND_WAIT;
            end else if (grant && cand_lvl == 9'(i)) begin
                next_cond = `PIL_COND_ACT;
            end
        end

        // Two condition bits plus enable per level
        always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cond[i] <= `PIL_COND_DIS;
                en[i] <= 1'b0;
            end else begin
                cond[i] <= next_cond;
                en[i] <= next_en;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status events
    // ----------------------------------------------------------------
    // Processor sees it one cycle later
    wire next_req = cand_beats;
    // Bad command, activation, request rise
    wire [2:0] int_ev = {cmd_bad, grant, next_req && !req_o};
    // Set wins over a same-cycle write-one clear
    wire [2:0] next_sts = (int_sts & ~(wr_ists ? wdata_i[2:0] : 3'h0)) | int_ev;

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Status is rewritten every cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= `PIL_CTRL_RST;
            ord_lo <= `PIL_ORD_LO_RST;
            ord_hi <= `PIL_ORD_HI_RST;
            sel_lvl <= '0;
            int_sts <= `PIL_INT_RST;
            int_msk <= `PIL_INT_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wdata_i[1:0];
            end
            if (wr_ord_lo) begin
                ord_lo <= wdata_i;
            end
            if (wr_ord_hi) begin
                ord_hi <= wdata_i;
            end
            if (wr_lcmd) begin
                sel_lvl <= cmd_lvl;
            end
            if (wr_imsk) begin
                int_msk <= wdata_i[2:0];
            end
            int_sts <= next_sts;
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Zero for a missing level
    wire sel_ok = lvl_exists(sel_lvl);
    wire [2:0] sel_state = sel_ok ? {en[sel_lvl], cond[sel_lvl]} : 3'h0;
    wire [31:0] rd_lcmd = {7'h00, sel_lvl, 13'h0000, sel_state};
    // Flags, current level, candidate
    wire [31:0] rd_req = {req_o, cur_valid_o, 5'h00, cur_level_o, 7'h00, req_level_o};

    // Unmapped offsets read zero
    logic [31:0] rd_mux;
    always_comb begin
        case (addr_i)
            `PIL_OFF_CTRL: rd_mux = {30'h0, ctrl};
            `PIL_OFF_ORD_LO: rd_mux = ord_lo;
            `PIL_OFF_ORD_HI: rd_mux = ord_hi;
            `PIL_OFF_LCMD: rd_mux = rd_lcmd;
            `PIL_OFF_REQ: rd_mux = rd_req;
            `PIL_OFF_ISTS: rd_mux = {29'h0, int_sts};
            `PIL_OFF_IMSK: rd_mux = {29'h0, int_msk};
            default: rd_mux = 32'h0;
        endcase
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Request identity refreshed every cycle for the processor to compare
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0;
            req_o <= 1'b0;
            req_level_o <= '0;
            act_o <= 1'b0;
            act_level_o <= '0;
            cur_valid_o <= 1'b0;
            cur_level_o <= '0;
            irq_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0;
            req_o <= next_req;
            req_level_o <= best_e_v ? cand_lvl : 9'h000;
            // Activation pulse and its level
            act_o <= grant;
            act_level_o <= grant ? cand_lvl : act_level_o;
            cur_valid_o <= best_a_v;
            cur_level_o <= best_a_v ? cur_lvl : 9'h000;
            // Follows the status just written
            irq_o <= |(next_sts & int_msk);
        end
    end

endmodule // pil_ctrl

//--- rtl/pil_params.svh
`ifndef PIL_PARAMS_SVH
`define PIL_PARAMS_SVH

// ----------------------------------------------------------------
// Group sizes
// ----------------------------------------------------------------
`define PIL_OVR_LEVELS 8
`define PIL_CNT_LEVELS 4
`define PIL_IO_LEVELS 2
`define PIL_EXT_GROUPS 14
`define PIL_GRP_SLOTS 16
`define PIL_FIXED_GROUPS 3

// ----------------------------------------------------------------
// Group indices and fixed level positions
// ----------------------------------------------------------------
`define PIL_GRP_OVR 5'h00
`define PIL_GRP_CNT 5'h01
`define PIL_GRP_IO 5'h02
`define PIL_CNT_PULSE_BASE 4

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PIL_OFF_CTRL 8'h00
`define PIL_OFF_ORD_LO 8'h04
`define PIL_OFF_ORD_HI 8'h08
`define PIL_OFF_LCMD 8'h0c
`define PIL_OFF_REQ 8'h10
`define PIL_OFF_ISTS 8'h14
`define PIL_OFF_IMSK 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIL_CTRL_INT_INH 0
`define PIL_CTRL_EXT_INH 1
`define PIL_LCMD_CODE_LSB 12
`define PIL_LVL_MSB 8
`define PIL_RD_LVL_LSB 16
`define PIL_RD_EN_BIT 2
`define PIL_REQ_VALID_BIT 31
`define PIL_REQ_ACT_BIT 30
`define PIL_INT_REQ 0
`define PIL_INT_ACT 1
`define PIL_INT_BAD 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PIL_CTRL_RST 2'h0
`define PIL_ORD_LO_RST 32'h76543210
`define PIL_ORD_HI_RST 32'hfedcba98
`define PIL_INT_RST 3'h0

// ----------------------------------------------------------------
// Condition codes (first bit, second bit)
// ----------------------------------------------------------------
`define PIL_COND_DIS 2'h0
`define PIL_COND_ARM 2'h1
`define PIL_COND_WAIT 2'h3
`define PIL_COND_ACT 2'h2

// ----------------------------------------------------------------
// Level command codes
// ----------------------------------------------------------------
`define PIL_CMD_ARM 4'h1
`define PIL_CMD_DISARM 4'h2
`define PIL_CMD_ENABLE 4'h3
`define PIL_CMD_DISABLE 4'h4
`define PIL_CMD_TRIGGER 4'h5
`define PIL_CMD_RELEASE 4'h6
`define PIL_CMD_ARM_EN 4'h7

`endif

//--- rtl/pil_pkg.sv
package pil_pkg;
    // Two condition bits of one level
    typedef logic [1:0] pil_cond_t;
    // Level command code
    typedef logic [3:0] pil_cmd_t;
    // Flat level number: group in [8:4], position in [3:0]
    typedef logic [8:0] pil_lvl_t;
    // Priority key: rank, group, position; lower wins
    typedef logic [13:0] pil_key_t;
endpackage : pil_pkg

//--- test/pil_cpu_model.sv
// ----------------------------------------------------------------
// Processor side: answers requests, then pauses a chosen time before the next answer
// ----------------------------------------------------------------
module pil_cpu_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic go_i,
    input wire logic busy_i,
    input wire logic [3:0] delay_i,
    output logic cpu_intpt_o,
    output logic cpu_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_q;
    logic [3:0] wait_q;

    // One-cycle acknowledge, then a pause before the next one
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            wait_q <= 4'h0;
        end else if (ack_q) begin
            ack_q <= 1'b0;
            wait_q <= delay_i;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else begin
            ack_q <= go_i && req_i;
        end
    end

    // A busy processor answers but is not at an interruptible point
    assign cpu_ack_o = ack_q;
    assign cpu_intpt_o = ack_q && !busy_i;
endmodule // pil_cpu_model

//--- test/pil_ctrl_bench.sv
`include "pil_params.svh"

// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module pil_ctrl_bench
    import pil_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] ovr_trig_i = 8'h00;
    logic [3:0] cnt_zero_i = 4'h0;
    logic [1:0] io_trig_i = 2'h0;
    logic [223:0] ext_trig_i = '0;
    logic go = 1'b0;
    logic busy = 1'b0;
    logic [3:0] delay = 4'h0;
    logic cpu_intpt_i, cpu_ack_i, req_o, act_o, cur_valid_o, irq_o;
    logic [31:0] rdata_o;
    logic [8:0] req_level_o, act_level_o, cur_level_o;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    integer seed = 32'h8c7cb020;

    pil_ctrl dut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .ovr_trig_i, .cnt_zero_i, .io_trig_i, .ext_trig_i, .cpu_intpt_i, .cpu_ack_i,
        .req_o, .req_level_o, .act_o, .act_level_o, .cur_valid_o, .cur_level_o, .irq_o);
    pil_cpu_model cpu (.mclk_i, .rst_n_i, .req_i(req_o), .go_i(go), .busy_i(busy),
        .delay_i(delay), .cpu_intpt_o(cpu_intpt_i), .cpu_ack_o(cpu_ack_i));

    // Clock and hang guard; the run needs far fewer cycles
    always #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] lstate(pil_lvl_t l, logic en, pil_cond_t c);
        return {7'h0, l, 13'h0, en, c};
    endfunction
    function automatic pil_lvl_t first(pil_lvl_t a, pil_lvl_t b);
        return (a < b) ? a : b;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic restart();
        rst_n_i <= 1'b0;
        tick(10);
        rst_n_i <= 1'b1;
        tick(1);
    endtask
    // Writes leave one idle cycle so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i);
        check(rdata_o, exp);
    endtask
    task automatic cmd(input pil_cmd_t c, input pil_lvl_t l);
        wr(`PIL_OFF_LCMD, {16'h0, c, 3'h0, l});
    endtask
    task automatic lchk(input pil_lvl_t l, input logic en, input pil_cond_t c);
        cmd(4'h0, l);
        rd_chk(`PIL_OFF_LCMD, lstate(l, en, c));
    endtask
    task automatic pulse_ext(input logic [223:0] m);
        ext_trig_i <= m;
        @(posedge mclk_i);
        ext_trig_i <= '0;
        tick(3);
    endtask
    task automatic grant(input pil_lvl_t l);
        int i;
        busy <= 1'b0;
        go <= 1'b1;
        for (i = 0; i < 40 && act_o !== 1'b1; i++) begin
            @(posedge mclk_i);
        end
        go <= 1'b0;
        check(act_level_o, l);
    endtask

    // Main sequence
    initial begin
        int j1, j2, k;
        pil_lvl_t l1, l2;
        restart();
        rd_chk(`PIL_OFF_ORD_LO, `PIL_ORD_LO_RST);
        rd_chk(`PIL_OFF_ORD_HI, `PIL_ORD_HI_RST);
        rd_chk(8'h1c, 32'h0);
        pulse_ext(224'h1);
        check(req_o, 1'b0);
        lchk(9'h030, 1'b0, `PIL_COND_DIS);
        cmd(`PIL_CMD_ARM, 9'h030);
        cmd(`PIL_CMD_ARM_EN, 9'h031);
        cmd(`PIL_CMD_ARM_EN, 9'h032);
        pulse_ext(224'h7);
        check(req_level_o, 9'h031);
        lchk(9'h030, 1'b0, `PIL_COND_WAIT);
        cmd(`PIL_CMD_ENABLE, 9'h030);
        tick(3);
        check(req_level_o, 9'h030);
        cmd(`PIL_CMD_DISABLE, 9'h030);
        busy <= 1'b1;
        go <= 1'b1;
        tick(8);
        go <= 1'b0;
        lchk(9'h031, 1'b1, `PIL_COND_WAIT);
        grant(9'h031);
        lchk(9'h031, 1'b1, `PIL_COND_ACT);
        check(req_o, 1'b0);
        cmd(`PIL_CMD_ARM_EN, 9'h000);
        ovr_trig_i <= 8'h01;
        tick(1);
        ovr_trig_i <= 8'h00;
        tick(3);
        check(req_o, 1'b1);
        grant(9'h000);
        cmd(`PIL_CMD_DISARM, 9'h000);
        tick(3);
        check(cur_level_o, 9'h031);
        // Inhibits, then group order turned round
        restart();
        cmd(`PIL_CMD_ARM_EN, 9'h020);
        cmd(`PIL_CMD_ARM_EN, 9'h040);
        wr(`PIL_OFF_CTRL, 32'h3);
        io_trig_i <= 2'h1;
        pulse_ext(224'h1 << 16);
        io_trig_i <= 2'h0;
        check(req_o, 1'b0);
        lchk(9'h020, 1'b1, `PIL_COND_WAIT);
        wr(`PIL_OFF_CTRL, 32'h1);
        tick(3);
        check(req_level_o, 9'h040);
        grant(9'h040);
        wr(`PIL_OFF_CTRL, 32'h0);
        tick(3);
        check(req_o, 1'b1);
        wr(`PIL_OFF_ORD_LO, 32'h76540321);
        tick(3);
        check(req_o, 1'b0);
        // Count pulse level drives its count-equal-zero partner
        restart();
        cmd(`PIL_CMD_ARM_EN, 9'h004);
        cmd(`PIL_CMD_TRIGGER, 9'h004);
        tick(3);
        check(req_level_o, 9'h004);
        grant(9'h004);
        cmd(`PIL_CMD_ARM_EN, 9'h010);
        cmd(`PIL_CMD_ARM_EN, 9'h011);
        cnt_zero_i <= 4'h3;
        tick(1);
        cnt_zero_i <= 4'h0;
        lchk(9'h010, 1'b1, `PIL_COND_WAIT);
        lchk(9'h011, 1'b1, `PIL_COND_ARM);
        cmd(`PIL_CMD_RELEASE, 9'h004);
        tick(3);
        check(cur_valid_o, 1'b0);
        // Event status, mask and level interrupt
        restart();
        wr(`PIL_OFF_IMSK, 32'h1);
        cmd(`PIL_CMD_ARM_EN, 9'h033);
        pulse_ext(224'h8);
        check(irq_o, 1'b1);
        wr(`PIL_OFF_IMSK, 32'h0);
        tick(1);
        check(irq_o, 1'b0);
        cmd(`PIL_CMD_ARM_EN, 9'h110);
        wr(`PIL_OFF_ISTS, 32'h1);
        rd_chk(`PIL_OFF_ISTS, 32'h4);
        // Random pairs over all external levels, last two first
        for (k = 0; k < 8; k++) begin
            restart();
            j1 = (k == 0) ? 223 : {$random(seed)} % 224;
            j2 = (k == 0) ? 222 : {$random(seed)} % 224;
            l1 = 9'h030 + 9'(j1);
            l2 = 9'h030 + 9'(j2);
            cmd(`PIL_CMD_ARM_EN, l1);
            cmd(`PIL_CMD_ARM_EN, l2);
            pulse_ext((224'h1 << j1) | (224'h1 << j2));
            check(req_level_o, first(l1, l2));
            delay <= 4'($random(seed));
            grant(first(l1, l2));
        end
        print_verdict();
    end
endmodule // pil_ctrl_bench

//--- test/pil_ctrl_props.sv
`include "pil_params.svh"

// ----------------------------------------------------------------
// Port checker for the interrupt level controller
// ----------------------------------------------------------------
module pil_ctrl_props
    import pil_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic cpu_intpt_i,
    input wire logic cpu_ack_i,
    input wire logic req_o,
    input wire logic act_o,
    input wire logic [8:0] act_level_o,
    input wire logic cur_valid_o,
    input wire logic [8:0] cur_level_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // Shadows of inhibit and mask, so grants and interrupts can be judged
    logic [1:0] inh;
    logic [2:0] msk;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inh <= 2'h0;
            msk <= 3'h0;
        end else if (wr_i) begin
            inh <= (addr_i == `PIL_OFF_CTRL) ? wdata_i[1:0] : inh;
            msk <= (addr_i == `PIL_OFF_IMSK) ? wdata_i[2:0] : msk;
        end
    end

    act_cause_a: assert property (act_o |-> $past(cpu_intpt_i && cpu_ack_i))
        else $error("activation without interruptible acknowledge");
    grant_taken_a: assert property (req_o && !act_o && cpu_intpt_i && cpu_ack_i && !wr_i
        && !$past(wr_i) |=> act_o) else $error("eligible request not granted");
    act_cur_a: assert property (act_o |=> cur_valid_o && cur_level_o == $past(act_level_o))
        else $error("activated level not the current one");
    io_inhibit_a: assert property (act_o |-> !($past(inh[0]) && act_level_o[8:4] == 5'h02))
        else $error("input/output level granted while inhibited");
    ext_inhibit_a: assert property (act_o |-> !($past(inh[1]) && act_level_o[8:4] > 5'h02))
        else $error("external level granted while inhibited");
    fall_needs_cmd_a: assert property ($fell(cur_valid_o) |-> $past(wr_i, 2))
        else $error("active level left without a command");
    idle_level_a: assert property (!cur_valid_o |-> cur_level_o == 9'h000)
        else $error("current level shown while none active");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its cycle");
    irq_mask_a: assert property ($rose(irq_o) |-> $past(msk) != 3'h0)
        else $error("interrupt raised with all events masked");

    cover property (act_o);
    cover property ($fell(cur_valid_o));
    cover property ($rose(irq_o));
endmodule // pil_ctrl_props

bind pil_ctrl pil_ctrl_props u_props (
    .mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .cpu_intpt_i, .cpu_ack_i, .req_o, .act_o, .act_level_o,
    .cur_valid_o, .cur_level_o, .irq_o
);
